// ===== design/llp_pkg.sv
package llp_pkg;

  localparam int PRESS_W = 12;
  localparam int NUM_CH = 3;
  // pressure counts are psig, full scale 2500
  localparam logic [PRESS_W-1:0] PRESS_FULL_SCALE = 12'h9c4;
  localparam logic [PRESS_W-1:0] LOW_LOW_TRIP_SETPOINT = 12'h226;
  localparam logic [PRESS_W-1:0] BYPASS_ALLOW_SETPOINT = 12'h37a;
  localparam logic [PRESS_W-1:0] BYPASS_REMOVAL_SETPOINT = 12'h37a;
  localparam int VOTE_NEED = 2;

  typedef enum logic [2:0] {
    BYP_OFF = 3'b001,
    BYP_ARMED = 3'b010,
    BYP_ACTIVE = 3'b100
  } bypass_state_t;

  typedef struct packed {
    logic [NUM_CH-1:0][PRESS_W-1:0] pressure;
    logic building_high_pressure_trip;
    logic [NUM_CH-1:0] bypass_switch;
    logic manual_trip;
    logic manual_reset;
  } field_in_t;

  typedef struct packed {
    logic [NUM_CH-1:0] channel_trip;
    logic [NUM_CH-1:0] bypass_permissive;
    logic [NUM_CH-1:0] bypass_lamp;
    logic bypass_annunciator;
    logic actuate_ch3;
    logic actuate_ch4;
  } field_out_t;

endpackage

// ===== design/llp_channel.sv
`timescale 1ns/1ps
`default_nettype none
module llp_channel
  import llp_pkg::*;
#(
  parameter logic [PRESS_W-1:0] TRIP_SP = LOW_LOW_TRIP_SETPOINT,
  parameter logic [PRESS_W-1:0] ALLOW_SP = BYPASS_ALLOW_SETPOINT,
  parameter logic [PRESS_W-1:0] REMOVE_SP = BYPASS_REMOVAL_SETPOINT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // sampled pressure and commands
  input wire logic [PRESS_W-1:0] measured_coolant_pressure,
  input wire logic building_high_pressure_trip,
  input wire logic bypass_in_effect,
  input wire logic manual_reset,
  // results
  output logic channel_trip,
  output logic low_low_raw,
  output logic permissive
);
  typedef struct packed {
    logic trip;
  } ch_state_t;

  ch_state_t s_q, s_d;
  logic [PRESS_W-1:0] p_clamped;

  always_comb begin
    // values above full scale are treated as full scale
    p_clamped = (measured_coolant_pressure > PRESS_FULL_SCALE) ?
                PRESS_FULL_SCALE : measured_coolant_pressure;
    low_low_raw = (p_clamped <= TRIP_SP);
    permissive = (p_clamped <= ALLOW_SP) && (p_clamped < REMOVE_SP);
    s_d = s_q;
    // bypass masks only the pressure term, never the building trip
    if ((low_low_raw && !bypass_in_effect) || building_high_pressure_trip) begin
      s_d.trip = 1'b1;
    end else if (manual_reset && !low_low_raw) begin
      s_d.trip = 1'b0;
    end
    channel_trip = s_q.trip;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ===== design/low_low_pressure_trip_voter.sv
// Notes on behaviour
// - channel trips when its pressure is at or below the low-low setpoint
// - each channel handles its own pressure, span 0 to 2500
// - two of three channel trips actuate output channels 3 and 4
// - building high pressure trip is ORed into each channel trip
// - bypass permissive when pressure is at or below the allow setpoint
// - active bypass clears when pressure reaches the removal setpoint
// - after auto removal, bypass needs a fresh operator request
// - bypass masks only the low-low trip, never building trip
// - three bypass switches; bypass takes effect with two of three operated
// - bypass in effect drives annunciator and switch lamps
// - manual trip pushbutton actuates output channels 3 and 4
// - manual path bypasses the automatic voting entirely
// - actuation is latched, not following momentary trip inputs
`timescale 1ns/1ps
`default_nettype none
module low_low_pressure_trip_voter
  import llp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // field inputs
  input wire field_in_t field_in,
  // field outputs
  output field_out_t field_out
);
  typedef struct packed {
    bypass_state_t byp;
    logic [NUM_CH-1:0] sw_prev;
    logic auto_act;
    logic manual_act;
    field_out_t out;
  } state_t;

  state_t s_q, s_d;
  logic [NUM_CH-1:0] ch_trip;
  logic [NUM_CH-1:0] ch_raw;
  logic [NUM_CH-1:0] ch_perm;
  logic [NUM_CH-1:0] ch_allow;
  logic bypass_in_effect;

  assign bypass_in_effect = (s_q.byp == BYP_ACTIVE);

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    llp_channel u_ch (
      .clock(clock),
      .rstn(rstn),
      .measured_coolant_pressure(field_in.pressure[i]),
      .building_high_pressure_trip(field_in.building_high_pressure_trip),
      .bypass_in_effect(bypass_in_effect),
      .manual_reset(field_in.manual_reset),
      .channel_trip(ch_trip[i]),
      .low_low_raw(ch_raw[i]),
      .permissive(ch_perm[i])
    );
    // shown permissive includes the setpoint itself; arming also needs the removal band
    assign ch_allow[i] = (field_in.pressure[i] <= BYPASS_ALLOW_SETPOINT);
  end

  function automatic logic two_of_three(input logic [NUM_CH-1:0] v);
    logic [1:0] n;
    n = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    return n >= 2'(VOTE_NEED);
  endfunction

  logic sw_vote, perm_vote, new_request, any_raw;

  always_comb begin
    s_d = s_q;
    sw_vote = two_of_three(field_in.bypass_switch);
    perm_vote = two_of_three(ch_perm);
    any_raw = |ch_raw;
    // a request is a fresh switch closure so a held switch cannot rebypass
    new_request = sw_vote && !two_of_three(s_q.sw_prev);
    s_d.sw_prev = field_in.bypass_switch;
    case (s_q.byp)
      BYP_OFF: begin
        if (perm_vote) begin
          s_d.byp = BYP_ARMED;
        end
      end
      BYP_ARMED: begin
        if (!perm_vote) begin
          s_d.byp = BYP_OFF;
        end else if (new_request) begin
          s_d.byp = BYP_ACTIVE;
        end
      end
      BYP_ACTIVE: begin
        if (!perm_vote) begin
          s_d.byp = BYP_OFF;
        end
      end
      default: s_d.byp = BYP_OFF;
    endcase
    if (two_of_three(ch_trip)) begin
      s_d.auto_act = 1'b1;
    end else if (field_in.manual_reset && !any_raw) begin
      s_d.auto_act = 1'b0;
    end
    // manual path sees only the pushbuttons, not the voter
    if (field_in.manual_trip) begin
      s_d.manual_act = 1'b1;
    end else if (field_in.manual_reset) begin
      s_d.manual_act = 1'b0;
    end
    s_d.out.channel_trip = ch_trip;
    s_d.out.bypass_permissive = ch_allow;
    s_d.out.bypass_annunciator = (s_d.byp == BYP_ACTIVE);
    s_d.out.bypass_lamp = {NUM_CH{s_d.byp == BYP_ACTIVE}};
    s_d.out.actuate_ch3 = s_d.auto_act || s_d.manual_act;
    s_d.out.actuate_ch4 = s_d.auto_act || s_d.manual_act;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '{byp: BYP_OFF, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign field_out = s_q.out;
endmodule
`default_nettype wire

// ===== test/llp_field.sv
`timescale 1ns/1ps
`default_nettype none
module llp_field import llp_pkg::*; (
  // panel and transmitters as set
  input wire field_in_t demand,
  // lines into the block
  output field_in_t field_in
);
  assign field_in = demand; // one switch per channel, passed through unchanged
endmodule
`default_nettype wire

// ===== test/llp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module llp_properties import llp_pkg::*; (
  // watched ports
  input wire logic clock,
  input wire logic rstn,
  input wire field_in_t field_in,
  input wire field_out_t field_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  field_in_t fi;
  field_out_t fo;
  assign fi = field_in;
  assign fo = field_out;
  a_building_trips: assert property (fi.building_high_pressure_trip |-> ##2 &fo.channel_trip)
    else $error("building trip missed");
  a_building_actuates: assert property (fi.building_high_pressure_trip |-> ##3 fo.actuate_ch3)
    else $error("building actuation missed");
  a_vote_actuates: assert property ($rose(fo.channel_trip[0] & fo.channel_trip[1]) |=> fo.actuate_ch3)
    else $error("vote actuation missed");
  a_outputs_paired: assert property (fo.actuate_ch3 == fo.actuate_ch4)
    else $error("outputs differ");
  a_manual_actuates: assert property (fi.manual_trip |=> fo.actuate_ch4)
    else $error("manual actuation missed");
  a_actuation_held: assert property (fo.actuate_ch3 && !fi.manual_reset && !$past(fi.manual_reset) |=> fo.actuate_ch3)
    else $error("actuation dropped");
  a_permissive_low: assert property (fi.pressure[1] <= BYPASS_ALLOW_SETPOINT |=> fo.bypass_permissive[1])
    else $error("permissive missed");
  a_lamps_follow: assert property (fo.bypass_lamp == {3{fo.bypass_annunciator}})
    else $error("lamps differ");
  a_bypass_removed: assert property (fi.pressure[0] > BYPASS_REMOVAL_SETPOINT && fi.pressure[2] > BYPASS_REMOVAL_SETPOINT |-> ##2 !fo.bypass_annunciator)
    else $error("bypass kept");
  c_bypass: cover property ($rose(fo.bypass_annunciator));
  c_manual: cover property (fi.manual_trip ##1 fo.actuate_ch3);
  c_vote: cover property ($rose(fo.actuate_ch3) && fo.channel_trip[1]);
endmodule
`default_nettype wire

// ===== test/low_low_pressure_trip_voter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module low_low_pressure_trip_voter_tb_top import llp_pkg::*;;
  localparam logic [11:0] H = PRESS_FULL_SCALE;
  localparam logic [11:0] L = 12'h1f4;
  localparam logic [11:0] B = 12'h320;
  localparam logic [11:0] P = LOW_LOW_TRIP_SETPOINT;
  logic clock = 0;
  logic rstn = 0;
  field_in_t demand = {H, H, H, 6'h00};
  field_in_t field_in;
  field_out_t field_out;
  int mismatches = 0;
  int comparisons = 0;
  llp_field field_u (.demand(demand), .field_in(field_in));
  low_low_pressure_trip_voter dut_u (.clock(clock), .rstn(rstn), .field_in(field_in),
    .field_out(field_out));
  initial forever #25 clock = ~clock;
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR field_out expected %h seen %h", exp, seen);
    end
  endtask
  // ctl is {building, switches 2..0, manual trip, manual reset}
  task automatic step(input logic [11:0] p0, p1, p2, input logic [5:0] ctl, input int n,
      input logic [11:0] exp);
    @(posedge clock);
    demand <= {p2, p1, p0, ctl};
    repeat (n) @(posedge clock);
    #1;
    check(field_out, exp);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rstn <= 1;
    step(H, H, H, 6'h00, 1, 12'h000);
    step(P, P, H, 6'h00, 3, 12'h6c3);
    step(H, H, H, 6'h00, 3, 12'h603);
    step(L, H, H, 6'h01, 3, 12'h243);
    step(H, H, H, 6'h01, 3, 12'h000);
    step(H, H, 12'h000, 6'h00, 3, 12'h900);
    step(H, H, H, 6'h01, 3, 12'h000);
    $display("vote and reset test done");
    step(12'h37a, 12'h37a, H, 6'h00, 2, 12'h0c0);
    step(B, B, H, 6'h00, 2, 12'h0c0);
    step(B, B, H, 6'h04, 3, 12'h0c0);
    step(B, B, H, 6'h0c, 3, 12'h0fc);
    step(L, L, H, 6'h0c, 3, 12'h0fc);
    step(L, L, H, 6'h2c, 4, 12'heff);
    step(H, H, H, 6'h0c, 3, 12'he03);
    step(B, B, H, 6'h0c, 3, 12'hec3);
    step(B, B, H, 6'h01, 3, 12'h0c0);
    step(B, B, H, 6'h0c, 3, 12'h0fc);
    step(H, H, H, 6'h00, 3, 12'h000);
    $display("bypass test done");
    step(H, H, H, 6'h02, 1, 12'h003);
    step(H, H, H, 6'h00, 3, 12'h003);
    step(H, H, H, 6'h01, 2, 12'h000);
    $display("manual test done");
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end
endmodule
bind low_low_pressure_trip_voter llp_properties chk_u (.clock(clock), .rstn(rstn),
  .field_in(field_in), .field_out(field_out));
`default_nettype wire
